// File: src/mbc_pkg.sv
/*
  Shared constants and decode helpers for the multi-bank clock divide and
  skew block. Assumes one time unit equals one sys_clk period in this model.
*/
package mbc_pkg;

  // three-level strap codes after decode
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_MID = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;

  // multiplication factor per range, low-speed and high-speed variants
  localparam logic [6:0] N_LS_LOW = 7'h40;
  localparam logic [6:0] N_LS_MID = 7'h20;
  localparam logic [6:0] N_LS_HIGH = 7'h10;
  localparam logic [6:0] N_HS_LOW = 7'h20;
  localparam logic [6:0] N_HS_MID = 7'h10;
  localparam logic [6:0] N_HS_HIGH = 7'h08;

  // nominal band limits in MHz
  localparam logic [7:0] BAND_LS_LOW_MIN = 8'h0C;
  localparam logic [7:0] BAND_LS_LOW_MAX = 8'h1A;
  localparam logic [7:0] BAND_LS_MID_MIN = 8'h18;
  localparam logic [7:0] BAND_LS_MID_MAX = 8'h34;
  localparam logic [7:0] BAND_LS_HIGH_MIN = 8'h30;
  localparam logic [7:0] BAND_LS_HIGH_MAX = 8'h64;
  localparam logic [7:0] BAND_HS_LOW_MIN = 8'h18;
  localparam logic [7:0] BAND_HS_LOW_MAX = 8'h34;
  localparam logic [7:0] BAND_HS_MID_MIN = 8'h30;
  localparam logic [7:0] BAND_HS_MID_MAX = 8'h64;
  localparam logic [7:0] BAND_HS_HIGH_MIN = 8'h60;
  localparam logic [7:0] BAND_HS_HIGH_MAX = 8'hC8;

  // nominal cycles per alignment epoch: common multiple of all ratios
  localparam logic [6:0] EPOCH_CYCLES = 7'h78;
  // feedback bank skew magnitude in time units
  localparam int FB_SKEW_UNITS = 4;
  // centre of the nine-entry skew code
  localparam int SKEW_CENTRE = 4;

  // reset values of a bank's configuration (low range, divide by one)
  localparam logic [9:0] CFG_PERIOD_RST = 10'h040;
  localparam logic [9:0] CFG_HALF_RST = 10'h020;
  localparam logic [9:0] CFG_START_RST = 10'h000;
  localparam logic [6:0] N_RST = 7'h40;

  // sense[1]: pin level under weak pull-down, sense[0]: under weak pull-up
  function automatic logic [1:0] mbc_decode3(input logic [1:0] sense);
    logic [1:0] code;
    case (sense)
      2'h3: code = TRI_HIGH;
      2'h0: code = TRI_LOW;
      default: code = TRI_MID;
    endcase
    return code;
  endfunction

  function automatic logic [3:0] mbc_ratio(input logic [3:0] idx);
    logic [3:0] r;
    case (idx)
      4'h0: r = 4'h1;
      4'h1: r = 4'h2;
      4'h2: r = 4'h3;
      4'h3: r = 4'h4;
      4'h4: r = 4'h5;
      4'h5: r = 4'h6;
      4'h6: r = 4'h8;
      4'h7: r = 4'hA;
      default: r = 4'hC;
    endcase
    return r;
  endfunction

  // outer banks: wide steps, two codes borrow the inner banks' skew
  function automatic int mbc_outer_skew(input logic [3:0] idx, input int bk1, input int bk2);
    int s;
    case (idx)
      4'h0: s = -8;
      4'h1: s = -7;
      4'h2: s = -6;
      4'h3: s = bk1;
      4'h4: s = 0;
      4'h5: s = bk2;
      4'h6: s = 6;
      4'h7: s = 7;
      default: s = 8;
    endcase
    return s;
  endfunction

endpackage

// File: src/mbc_bank.sv
/*
  One output bank: per-bank position counter, divider phase and stop-when-low
  hold-off gate. Assumes step, epoch and configuration come from sys_clk logic.
*/
module mbc_bank
  import mbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic step,
  input wire logic epoch,
  input wire logic [9:0] period,
  input wire logic [9:0] half,
  input wire logic [9:0] start_pos,
  input wire logic hold_off,
  output logic clk_out
);

  logic [9:0] pos_reg;
  logic [9:0] pos_next;
  logic stop_reg;
  logic stop_next;
  logic out_reg;
  logic out_next;

  always_comb begin
    pos_next = pos_reg;
    if (step) begin
      if (epoch) begin
        pos_next = start_pos;
      end else if (pos_reg + 10'h001 >= period) begin
        pos_next = 10'h000;
      end else begin
        pos_next = pos_reg + 10'h001;
      end
    end
    // stop only once the clock is low, so entering hold-off cuts no pulse short
    stop_next = hold_off & (stop_reg | ~out_reg);
    out_next = ~stop_next & (pos_next < half);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pos_reg <= CFG_START_RST;
      stop_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      stop_reg <= stop_next;
      out_reg <= out_next;
    end
  end

  assign clk_out = out_reg;

endmodule

// File: src/mbc_clock_top.sv
/*
  Multi-bank clock divide and skew block: digital phase generator, reference
  and feedback selection, strap decode and five output banks.
  Assumes one skew time unit per sys_clk period and reference at nominal rate.
*/
module mbc_clock_top
  import mbc_pkg::*;
#(
  parameter bit HIGH_SPEED = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reference_pair_one,
  input wire logic reference_pair_two,
  input wire logic reference_choice,
  input wire logic feedback_input_one,
  input wire logic feedback_input_two,
  input wire logic [1:0] freq_range_select,
  input wire logic [1:0] feedback_phase_select,
  input wire logic [3:0] feedback_divider_select,
  input wire logic [15:0] bank_phase_select,
  input wire logic [15:0] bank_divider_select,
  input wire logic [3:0] bank_output_off,
  input wire logic feedback_bank_off,
  output logic [15:0] bank_outputs,
  output logic [1:0] feedback_bank_outputs,
  output logic [6:0] n_factor,
  output logic [7:0] band_min_mhz,
  output logic [7:0] band_max_mhz
);

  localparam int IN_W = 50;
  localparam int BANKS = 5;

  // pin synchroniser group
  logic [IN_W-1:0] pin_raw;
  logic [IN_W-1:0] s1_reg;
  logic [IN_W-1:0] s2_reg;
  logic [IN_W-1:0] s3_reg;
  logic [IN_W-1:0] acc_reg;
  logic [IN_W-1:0] acc_next;

  assign pin_raw = {reference_pair_one, reference_pair_two, reference_choice,
                    feedback_input_one, feedback_input_two, bank_output_off,
                    feedback_bank_off, freq_range_select, feedback_phase_select,
                    feedback_divider_select, bank_phase_select, bank_divider_select};

  always_comb begin
    // a bit is taken only when the second and third stage agree
    acc_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (acc_reg & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      acc_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      acc_reg <= acc_next;
    end
  end

  logic ref_one_s;
  logic ref_two_s;
  logic choice_s;
  logic fb_one_s;
  logic fb_two_s;
  logic [3:0] off_s;
  logic fb_off_s;
  logic [1:0] range_s;
  logic [1:0] fb_phase_s;
  logic [3:0] fb_div_s;
  logic [15:0] phase_s;
  logic [15:0] div_s;

  assign {ref_one_s, ref_two_s, choice_s, fb_one_s, fb_two_s, off_s, fb_off_s,
          range_s, fb_phase_s, fb_div_s, phase_s, div_s} = acc_reg;

  // reference and feedback selection, edge detect
  logic ref_sel;
  logic fb_sel;
  logic ref_prev_reg;
  logic fb_prev_reg;
  logic ref_rise;
  logic fb_rise;

  assign ref_sel = choice_s ? ref_two_s : ref_one_s;
  assign fb_sel = choice_s ? fb_two_s : fb_one_s;
  assign ref_rise = ref_sel & ~ref_prev_reg;
  assign fb_rise = fb_sel & ~fb_prev_reg;

  // configuration group
  logic [6:0] n_reg;
  logic [6:0] n_next;
  logic [7:0] bmin_reg;
  logic [7:0] bmin_next;
  logic [7:0] bmax_reg;
  logic [7:0] bmax_next;
  logic [9:0] per_reg [BANKS];
  logic [9:0] per_next [BANKS];
  logic [9:0] half_reg [BANKS];
  logic [9:0] half_next [BANKS];
  logic [9:0] start_reg [BANKS];
  logic [9:0] start_next [BANKS];

  always_comb begin
    logic [1:0] range_c;
    logic [1:0] hi;
    logic [1:0] lo;
    logic [3:0] idx;
    logic [3:0] ratio;
    int skew [BANKS];
    int fb_skew;
    int per;
    int rel;
    hi = TRI_LOW;
    lo = TRI_LOW;
    idx = 4'h0;
    ratio = 4'h1;
    fb_skew = 0;
    per = 0;
    rel = 0;
    range_c = mbc_decode3(range_s);
    unique case (range_c)
      TRI_LOW: begin
        n_next = HIGH_SPEED ? N_HS_LOW : N_LS_LOW;
        bmin_next = HIGH_SPEED ? BAND_HS_LOW_MIN : BAND_LS_LOW_MIN;
        bmax_next = HIGH_SPEED ? BAND_HS_LOW_MAX : BAND_LS_LOW_MAX;
      end
      TRI_MID: begin
        n_next = HIGH_SPEED ? N_HS_MID : N_LS_MID;
        bmin_next = HIGH_SPEED ? BAND_HS_MID_MIN : BAND_LS_MID_MIN;
        bmax_next = HIGH_SPEED ? BAND_HS_MID_MAX : BAND_LS_MID_MAX;
      end
      default: begin
        n_next = HIGH_SPEED ? N_HS_HIGH : N_LS_HIGH;
        bmin_next = HIGH_SPEED ? BAND_HS_HIGH_MIN : BAND_LS_HIGH_MIN;
        bmax_next = HIGH_SPEED ? BAND_HS_HIGH_MAX : BAND_LS_HIGH_MAX;
      end
    endcase
    unique case (mbc_decode3(fb_phase_s))
      TRI_LOW: fb_skew = -FB_SKEW_UNITS;
      TRI_MID: fb_skew = 0;
      default: fb_skew = FB_SKEW_UNITS;
    endcase
    for (int b = 0; b < BANKS; b++) begin
      skew[b] = 0;
    end
    for (int b = 0; b < BANKS; b++) begin
      if (b < 4) begin
        hi = mbc_decode3(phase_s[b*4+2 +: 2]);
        lo = mbc_decode3(phase_s[b*4 +: 2]);
        idx = 4'(hi * 3 + lo);
        if (b < 2) begin
          skew[b] = int'(idx) - SKEW_CENTRE;
        end else begin
          skew[b] = mbc_outer_skew(idx, skew[0], skew[1]);
        end
        hi = mbc_decode3(div_s[b*4+2 +: 2]);
        lo = mbc_decode3(div_s[b*4 +: 2]);
      end else begin
        skew[b] = fb_skew;
        hi = mbc_decode3(fb_div_s[3:2]);
        lo = mbc_decode3(fb_div_s[1:0]);
      end
      ratio = mbc_ratio(4'(hi * 3 + lo));
      // one nominal cycle is n time units, so divide-by-one is nominal rate
      per = int'(n_next) * int'(ratio);
      rel = skew[b] - fb_skew;
      per_next[b] = 10'(per);
      half_next[b] = 10'(per / 2);
      start_next[b] = 10'((2 * per - rel) % per);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      n_reg <= N_RST;
      bmin_reg <= BAND_LS_LOW_MIN;
      bmax_reg <= BAND_LS_LOW_MAX;
      for (int b = 0; b < BANKS; b++) begin
        per_reg[b] <= CFG_PERIOD_RST;
        half_reg[b] <= CFG_HALF_RST;
        start_reg[b] <= CFG_START_RST;
      end
    end else begin
      n_reg <= n_next;
      bmin_reg <= bmin_next;
      bmax_reg <= bmax_next;
      for (int b = 0; b < BANKS; b++) begin
        per_reg[b] <= per_next[b];
        half_reg[b] <= half_next[b];
        start_reg[b] <= start_next[b];
      end
    end
  end

  // phase generator and alignment loop group
  logic [6:0] tick_reg;
  logic [6:0] tick_next;
  logic [6:0] cyc_reg;
  logic [6:0] cyc_next;
  logic [6:0] ref_tick_reg;
  logic [6:0] ref_tick_next;
  logic stall_reg;
  logic stall_next;
  logic step;
  logic tick_wrap;
  logic epoch;

  assign step = ~stall_reg;
  assign tick_wrap = (tick_reg + 7'h01) >= n_reg;
  assign epoch = step & tick_wrap & ((cyc_reg + 7'h01) >= EPOCH_CYCLES);

  always_comb begin
    logic [6:0] ref_at;
    ref_at = ref_tick_reg;
    tick_next = tick_reg;
    cyc_next = cyc_reg;
    if (step) begin
      if (tick_wrap) begin
        tick_next = 7'h00;
        cyc_next = ((cyc_reg + 7'h01) >= EPOCH_CYCLES) ? 7'h00 : cyc_reg + 7'h01;
      end else begin
        tick_next = tick_reg + 7'h01;
      end
    end
    ref_at = ref_rise ? tick_reg : ref_tick_reg;
    ref_tick_next = ref_at;
    // a mismatch only ever pauses the generator: periods stretch, never shrink
    stall_next = fb_rise & (tick_reg != ref_at) & ~stall_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tick_reg <= 7'h00;
      cyc_reg <= 7'h00;
      ref_tick_reg <= 7'h00;
      stall_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      fb_prev_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      cyc_reg <= cyc_next;
      ref_tick_reg <= ref_tick_next;
      stall_reg <= stall_next;
      ref_prev_reg <= ref_sel;
      fb_prev_reg <= fb_sel;
    end
  end

  // banks: index 4 is the feedback bank
  logic [BANKS-1:0] bank_clk;
  logic [BANKS-1:0] bank_off;

  assign bank_off = {fb_off_s, off_s};

  for (genvar g = 0; g < BANKS; g++) begin : g_bank
    mbc_bank u_bank (
      .sys_clk(sys_clk),
      .reset(reset),
      .step(step),
      .epoch(epoch),
      .period(per_reg[g]),
      .half(half_reg[g]),
      .start_pos(start_reg[g]),
      .hold_off(bank_off[g]),
      .clk_out(bank_clk[g])
    );
  end

  for (genvar g = 0; g < 4; g++) begin : g_fan
    assign bank_outputs[g*4 +: 4] = {4{bank_clk[g]}};
  end
  assign feedback_bank_outputs = {2{bank_clk[4]}};
  assign n_factor = n_reg;
  assign band_min_mhz = bmin_reg;
  assign band_max_mhz = bmax_reg;

endmodule

// File: verif/mbc_clock_sva.sv
/* Port checker for mbc_clock_top.
   Assumes the single sys_clk domain; bound at the foot. */
module mbc_clock_sva
  import mbc_pkg::*;
#(
  parameter bit HIGH_SPEED = 1'b0
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] freq_range_select,
  input wire logic [3:0] bank_output_off,
  input wire logic [15:0] bank_outputs,
  input wire logic [1:0] feedback_bank_outputs,
  input wire logic [6:0] n_factor,
  input wire logic [7:0] band_min_mhz,
  input wire logic [7:0] band_max_mhz
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // six periods at the slowest divide, plus sync slack
  localparam int OFF_MAX = 4616;
  // a range change re-phases banks; wait out one slow epoch
  localparam int RNG_MAX = 8000;
  int off_reg, off_next, rng_reg, rng_next;
  logic [1:0] rng_q_reg;
  always_comb begin
    off_next = bank_output_off[1] ? off_reg + int'(off_reg < OFF_MAX) : 0;
    rng_next = (freq_range_select != rng_q_reg) ? 0 : rng_reg + int'(rng_reg < RNG_MAX);
  end
  always_ff @(posedge sys_clk) begin
    off_reg <= reset ? 0 : off_next;
    rng_reg <= reset ? 0 : rng_next;
    rng_q_reg <= freq_range_select;
  end
  sequence s_range(logic [1:0] code);
    (freq_range_select == code) [*8];
  endsequence
  a_reset_defaults: assert property (disable iff (1'b0) reset |=>
      bank_outputs == 16'h0000 && n_factor == N_RST)
    else $error("outputs not cleared by reset");
  a_bank_copies: assert property (bank_outputs == {{4{bank_outputs[12]}},
      {4{bank_outputs[8]}}, {4{bank_outputs[4]}}, {4{bank_outputs[0]}}})
    else $error("bank outputs differ");
  a_fb_pair: assert property (feedback_bank_outputs[0] == feedback_bank_outputs[1])
    else $error("feedback outputs differ");
  a_factor_low: assert property (s_range(2'h0) |->
      n_factor == (HIGH_SPEED ? N_HS_LOW : N_LS_LOW))
    else $error("low range factor wrong");
  a_band_mid: assert property (s_range(2'h1) |->
      band_min_mhz == (HIGH_SPEED ? BAND_HS_MID_MIN : BAND_LS_MID_MIN))
    else $error("mid band wrong");
  a_factor_high: assert property (s_range(2'h3) |->
      n_factor == (HIGH_SPEED ? N_HS_HIGH : N_LS_HIGH) &&
      band_max_mhz == (HIGH_SPEED ? BAND_HS_HIGH_MAX : BAND_LS_HIGH_MAX))
    else $error("high range factor wrong");
  a_off_holds: assert property (off_reg == OFF_MAX |-> bank_outputs[7:4] == 4'h0)
    else $error("disabled bank still toggles");
  a_fb_high_min: assert property (rng_reg == RNG_MAX && $rose(feedback_bank_outputs[0]) |->
      feedback_bank_outputs[0] [*4])
    else $error("feedback high phase too short");
endmodule

bind mbc_clock_top mbc_clock_sva #(.HIGH_SPEED(HIGH_SPEED)) u_sva (.sys_clk(sys_clk),
  .reset(reset), .freq_range_select(freq_range_select), .bank_output_off(bank_output_off),
  .bank_outputs(bank_outputs), .feedback_bank_outputs(feedback_bank_outputs),
  .n_factor(n_factor), .band_min_mhz(band_min_mhz), .band_max_mhz(band_max_mhz));

// File: verif/mbc_board.sv
/* Board model: two free-running reference oscillators and the feedback trace.
   Assumes PERIOD sys_clk cycles per nominal reference period. */
module mbc_board #(
  parameter int PERIOD = 8,
  parameter int SHIFT = 3
)
(
  input wire logic sys_clk,
  input wire logic fb_trace,
  output logic ref_one,
  output logic ref_two,
  output logic fb_one,
  output logic fb_two
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial ref_one = 1'b0;
  initial ref_two = 1'b0;
  // second source out of phase so a switch must really relock
  always @(posedge sys_clk) begin
    cnt <= (cnt + 1) % PERIOD;
    ref_one <= cnt < PERIOD / 2;
    ref_two <= ((cnt + SHIFT) % PERIOD) < PERIOD / 2;
  end
  assign fb_one = fb_trace;
  assign fb_two = fb_trace;
endmodule

// File: verif/mbc_clock_top_bench.sv
/* Self-checking bench for mbc_clock_top, fast variant, eight units per cycle.
   Assumes the board model feeds back feedback output zero. */
module mbc_clock_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reference_choice = 1'b0;
  logic [1:0] freq_range_select = 2'h3;
  logic [1:0] feedback_phase_select = 2'h1;
  logic [3:0] feedback_divider_select = 4'h0;
  logic feedback_bank_off = 1'b0;
  logic [15:0] bank_phase_select = 16'h5555;
  logic [15:0] bank_divider_select = 16'h0000;
  logic [3:0] bank_output_off = 4'h0;
  logic reference_pair_one, reference_pair_two, feedback_input_one, feedback_input_two;
  logic [15:0] bank_outputs;
  logic [1:0] feedback_bank_outputs;
  logic [6:0] n_factor;
  logic [7:0] band_min_mhz, band_max_mhz;
  int n_fail = 0;
  int checks_done = 0;
  wire logic [18:0] probe = {reference_pair_two, reference_pair_one,
    feedback_bank_outputs[0], bank_outputs};

  initial forever #50 sys_clk = ~sys_clk;

  mbc_clock_top #(.HIGH_SPEED(1'b1)) u_dut (.sys_clk, .reset, .reference_pair_one,
    .reference_pair_two, .reference_choice, .feedback_input_one, .feedback_input_two,
    .freq_range_select, .feedback_phase_select, .feedback_divider_select,
    .bank_phase_select, .bank_divider_select, .bank_output_off, .feedback_bank_off,
    .bank_outputs, .feedback_bank_outputs, .n_factor, .band_min_mhz, .band_max_mhz);

  mbc_board u_board (.sys_clk(sys_clk), .fb_trace(feedback_bank_outputs[0]),
    .ref_one(reference_pair_one), .ref_two(reference_pair_two),
    .fb_one(feedback_input_one), .fb_two(feedback_input_two));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s seen %0d exp %0d", $time, what, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  // cycles until probe bit b next rises; a rise in the current cycle is skipped
  task automatic rise(input int b, output int n);
    logic prev;
    prev = probe[b];
    n = 0;
    repeat (400) begin
      @(negedge sys_clk);
      n++;
      if (probe[b] === 1'b1 && prev === 1'b0) return;
      prev = probe[b];
    end
  endtask

  // strap level 0..2 to its sense pair; the pair 2'h2 would read as MID
  function automatic logic [1:0] lvl(input int l);
    return (l == 2) ? 2'h3 : 2'(l);
  endfunction

  function automatic int wrap8(input int s);
    int m;
    m = ((s % 8) + 8) % 8;
    return (m == 0) ? 8 : m;
  endfunction

  task automatic t_range;
    int nf [4] = '{32, 16, 16, 8};
    int lo [4] = '{24, 48, 48, 96};
    int hi [4] = '{52, 100, 100, 200};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      freq_range_select <= 2'(i);
      wait_cyc(8);
      check(n_factor, nf[i], "factor");
      check(band_min_mhz, lo[i], "band min");
      check(band_max_mhz, hi[i], "band max");
    end
    // the range change re-phases at the next epoch; let the loop relock first
    wait_cyc(1100);
    $display("range test done");
  endtask

  task automatic t_divide;
    int ratio [9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};
    int n;
    for (int i = 0; i < 9; i++) begin
      @(posedge sys_clk);
      bank_divider_select[3:0] <= {lvl(i / 3), lvl(i % 3)};
      wait_cyc(1100);
      rise(0, n);
      rise(0, n);
      check(n, 8 * ratio[i], "period");
    end
    @(posedge sys_clk);
    bank_divider_select[3:0] <= 4'h0;
    $display("divide test done");
  endtask

  task automatic t_skew;
    int outer [9] = '{-8, -7, -6, 1, 0, 3, 6, 7, 8};
    int n;
    for (int i = 0; i < 18; i++) begin
      @(posedge sys_clk);
      if (i < 9) begin
        bank_phase_select[3:0] <= {lvl(i / 3), lvl(i % 3)};
      end else begin
        // bank zero at +1, bank one at +3, so the copy codes are told apart
        bank_phase_select[11:0] <= {lvl((i - 9) / 3), lvl((i - 9) % 3), 8'hD7};
      end
      wait_cyc(1100);
      rise(16, n);
      rise(i < 9 ? 0 : 8, n);
      check(n, wrap8(i < 9 ? i - 4 : outer[i - 9]), "skew");
    end
    @(posedge sys_clk);
    bank_phase_select <= 16'h5555;
    $display("skew test done");
  endtask

  task automatic t_align;
    int n;
    wait_cyc(200);
    rise(17, n);
    rise(16, n);
    check(n, 8, "lock one");
    @(posedge sys_clk);
    reference_choice <= 1'b1;
    wait_cyc(300);
    rise(18, n);
    rise(16, n);
    check(n, 8, "lock two");
    @(posedge sys_clk);
    reference_choice <= 1'b0;
    $display("align test done");
  endtask

  task automatic t_off;
    int n;
    @(posedge sys_clk);
    bank_output_off[1] <= 1'b1;
    feedback_bank_off <= 1'b1;
    wait_cyc(6 * 8 + 4);
    repeat (20) begin
      @(negedge sys_clk);
      check(bank_outputs[7:4], 4'h0, "held off");
      check(feedback_bank_outputs, 2'h0, "fb held off");
    end
    wait_cyc(4600);
    @(posedge sys_clk);
    bank_output_off[1] <= 1'b0;
    feedback_bank_off <= 1'b0;
    wait_cyc(50);
    rise(16, n);
    rise(4, n);
    check(n, 8, "resume phase");
    $display("disable test done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    t_range;
    t_divide;
    t_skew;
    t_align;
    t_off;
    results;
  end

  // about twice the expected run length
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_fail++;
    results;
  end
endmodule
